// ---- inc/codec_frame_consts.svh ----
`ifndef CODEC_FRAME_CONSTS_SVH
`define CODEC_FRAME_CONSTS_SVH

// Register addresses in the control word
`define REG_MODE 3'h0
`define REG_CLK_ECHO 3'h1
`define REG_POWER 3'h2
`define REG_GAIN 3'h3
`define REG_DAC_TIMING 3'h4
`define REG_RESET_VAL 8'h00

// Control word layout
`define CW_CONTROL 15
`define CW_READ 14
`define CW_DEV_HI 13
`define CW_DEV_LO 11
`define CW_REG_HI 10
`define CW_REG_LO 8
`define CW_DATA_HI 7
`define CW_DATA_LO 0
`define DEV_ADDR_SELF 3'h0
`define DEV_ADDR_STEP 3'h1
`define WORD_ZERO 16'h0000

// Mode control register
`define MODE_DATA_SEL 0
`define MODE_MIXED 1
`define MODE_DC_HI 6
`define MODE_DC_LO 4
`define MODE_SW_RESET 7

// Clock and echo configuration register
`define CE_SCD_HI 3
`define CE_SCD_LO 2
`define CE_MCD_HI 6
`define CE_MCD_LO 4
`define CE_ECHO 7

// Power control register
`define PW_GLOBAL 0
`define PW_ADC 3
`define PW_DAC 4
`define PW_REF 5
`define PW_REFOUT 6
`define PW_HIGH_SUPPLY 7

// Gain and mute register
`define GN_IGS_HI 2
`define GN_IGS_LO 0
`define GN_MOD_RESET 3
`define GN_OGS_HI 6
`define GN_OGS_LO 4
`define GN_MUTE 7

// DAC timing register
`define DT_ADV_HI 4
`define DT_ADV_LO 0
`define DT_BYPASS 5

// Timing, in divided master clocks
`define FS_SLOW_DMCLKS 12'h800
`define FS_FAST_DMCLKS 12'h100
`define SWRESET_DMCLKS 3'h4
`define SCLK_DIV_AT_ZERO 4'h8

`endif

// ---- inc/codec_frame_pkg.sv ----
package codec_frame_pkg;

  typedef enum logic [1:0] {
    ST_PROGRAM = 2'b00,
    ST_DATA = 2'b01,
    ST_SW_RESET = 2'b10
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic [7:0] mode_ctrl;
    logic [7:0] clk_echo;
    logic [7:0] power;
    logic [7:0] gain;
    logic [7:0] dac_timing;
    logic rate_fast;
    logic [11:0] fs_cnt;
    logic ofs;
    logic [15:0] out_word;
    logic out_pend;
    logic [15:0] tx_word;
    logic [2:0] ifs_cnt;
    logic [15:0] dac_data;
    logic dac_load;
    logic [2:0] rst_cnt;
  } ctrl_state_t;

  typedef struct packed {
    logic [2:0] m_cnt;
    logic [3:0] s_cnt;
    logic dm_tick;
    logic s_tick;
  } div_state_t;

endpackage

// ---- logic/rate_ticks.sv ----
`timescale 1ns/1ns
`include "codec_frame_consts.svh"

module rate_ticks
  import codec_frame_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Divider settings
  input wire logic [2:0] master_clock_divider,
  input wire logic [1:0] serial_clock_divider,
  // Ticks
  output logic divided_master_clock_tick,
  output logic sclk_tick
);

  div_state_t s_q;
  div_state_t s_d;

  // Serial clock runs at divided_master_clock/8 for code 0, doubling per code step
  function automatic logic [3:0] sclk_period(input logic [1:0] code);
    sclk_period = `SCLK_DIV_AT_ZERO >> code;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.dm_tick = 1'b0;
    s_d.s_tick = 1'b0;
    if (s_q.m_cnt >= master_clock_divider) begin
      s_d.m_cnt = 3'h0;
      s_d.dm_tick = 1'b1;
      if (s_q.s_cnt >= sclk_period(serial_clock_divider) - 4'h1) begin
        s_d.s_cnt = 4'h0;
        s_d.s_tick = 1'b1;
      end else begin
        s_d.s_cnt = s_q.s_cnt + 4'h1;
      end
    end else begin
      s_d.m_cnt = s_q.m_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign divided_master_clock_tick = s_q.dm_tick;
  assign sclk_tick = s_q.s_tick;

endmodule

// ---- logic/codec_frame_ctrl.sv ----
`timescale 1ns/1ns
`include "codec_frame_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// How it works
// - Serial and master clock dividers in clock register
// - Clock register bit 7 enables control echo
// - Global power bit powers every section
// - Individual ADC, DAC, reference power bits
// - Reference output enable and high supply mode
// - Input and output gain select fields
// - Modulator reset and output mute bits
// - Five-bit DAC advance value
// - Interpolator bypass bit
// - Program mode treats frames as control words
// - Accept control word only at address zero
// - Nonzero address decremented and forwarded out
// - Output frame sync once serial enable active
// - Frame sync every 2048, then 256 dmclks
// - Program mode output words carry no samples
// - Data select set, mixed clear enters data
// - Data mode loads DAC at device count
// - Data mode ignores control until hardware reset
// - Bit 15 marks control, bit 14 read-back
// - Register select and eight-bit data fields
// - Device count from mode register bits 4-6
// - Resets clear registers within four dmclks
//////////////////////////////////////////////////////////////////////////////

module codec_frame_ctrl
  import codec_frame_pkg::*;
#(
  parameter logic [11:0] FS_SLOW_PERIOD = `FS_SLOW_DMCLKS,
  parameter logic [11:0] FS_FAST_PERIOD = `FS_FAST_DMCLKS
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // Serial link, frame level
  input wire logic SERIAL_ENABLE_PIN,
  input wire logic INPUT_FRAME_SYNC,
  input wire logic [15:0] RX_WORD,
  output logic OUTPUT_FRAME_SYNC,
  output logic [15:0] TX_WORD,
  output logic SERIAL_CLOCK_TICK,
  output logic DIVIDED_MASTER_CLOCK_TICK,
  // Converter side
  input wire logic [15:0] ADC_SAMPLE,
  output logic [15:0] DAC_DATA,
  output logic DAC_LOAD,
  output logic DATA_MODE,
  output logic SOFT_RESET_BUSY,
  // Clock and echo settings
  output logic [1:0] SERIAL_CLOCK_DIVIDER,
  output logic [2:0] MASTER_CLOCK_DIVIDER,
  output logic CONTROL_ECHO_ENABLE,
  // Power settings
  output logic ADC_POWER_ON,
  output logic DAC_POWER_ON,
  output logic REFERENCE_POWER_ON,
  output logic REFERENCE_OUTPUT_USE,
  output logic HIGH_SUPPLY_MODE,
  // Gain and timing settings
  output logic [2:0] INPUT_GAIN_SELECT,
  output logic [2:0] OUTPUT_GAIN_SELECT,
  output logic MODULATOR_RESET,
  output logic OUTPUT_MUTE,
  output logic [4:0] DAC_ADVANCE,
  output logic INTERPOLATOR_BYPASS
);

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic dm_tick;
  logic s_tick;

  //////////////////////////////////////////////////////////////////////////////

  // Section powered by its own bit or by the global override
  function automatic logic section_on(input logic [7:0] pwr, input int unsigned pos);
    section_on = pwr[`PW_GLOBAL] | pwr[pos];
  endfunction

  // Control word with its device address stepped down by one
  function automatic logic [15:0] step_address(input logic [15:0] w);
    logic [15:0] r;
    r = w;
    r[`CW_DEV_HI:`CW_DEV_LO] = w[`CW_DEV_HI:`CW_DEV_LO] - `DEV_ADDR_STEP;
    step_address = r;
  endfunction

  // Register contents for a read-back, zero for unused addresses
  function automatic logic [7:0] read_reg(input ctrl_state_t st, input logic [2:0] a);
    case (a)
      `REG_MODE: read_reg = st.mode_ctrl;
      `REG_CLK_ECHO: read_reg = st.clk_echo;
      `REG_POWER: read_reg = st.power;
      `REG_GAIN: read_reg = st.gain;
      `REG_DAC_TIMING: read_reg = st.dac_timing;
      default: read_reg = `REG_RESET_VAL;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  rate_ticks u_ticks (
    .clk(REF_CLK),
    .resetn(RESETN),
    .clk_en(CLK_EN),
    .master_clock_divider(s_q.clk_echo[`CE_MCD_HI:`CE_MCD_LO]),
    .serial_clock_divider(s_q.clk_echo[`CE_SCD_HI:`CE_SCD_LO]),
    .divided_master_clock_tick(dm_tick),
    .sclk_tick(s_tick)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [2:0] dev;
    logic [2:0] ra;
    logic [7:0] val;
    logic [2:0] dc;
    logic [3:0] next_cnt;
    dev = RX_WORD[`CW_DEV_HI:`CW_DEV_LO];
    ra = RX_WORD[`CW_REG_HI:`CW_REG_LO];
    val = RX_WORD[`CW_DATA_HI:`CW_DATA_LO];
    dc = s_q.mode_ctrl[`MODE_DC_HI:`MODE_DC_LO];
    next_cnt = {1'b0, s_q.ifs_cnt} + 4'h1;
    s_d = s_q;
    s_d.ofs = 1'b0;
    s_d.dac_load = 1'b0;

    if (SERIAL_ENABLE_PIN && dm_tick) begin
      if (s_q.fs_cnt == 12'h000) begin
        s_d.ofs = 1'b1;
        // slow rate until clock register written
        s_d.fs_cnt = (s_q.rate_fast ? FS_FAST_PERIOD : FS_SLOW_PERIOD) - 12'h001;
      end else begin
        s_d.fs_cnt = s_q.fs_cnt - 12'h001;
      end
    end

    // Output word leaves at each frame sync; a pending word goes first
    if (s_d.ofs) begin
      s_d.out_pend = 1'b0;
      s_d.ifs_cnt = 3'h0;
      if (s_q.out_pend) begin
        s_d.tx_word = s_q.out_word;
      end else if (s_q.mode == ST_DATA) begin
        s_d.tx_word = ADC_SAMPLE;
      end else begin
        s_d.tx_word = `WORD_ZERO;
      end
    end

    case (s_q.mode)
      ST_PROGRAM: begin
        if (INPUT_FRAME_SYNC && RX_WORD[`CW_CONTROL]) begin
          if (dev != `DEV_ADDR_SELF) begin
            s_d.out_word = step_address(RX_WORD);
            s_d.out_pend = 1'b1;
          end else if (RX_WORD[`CW_READ]) begin
            s_d.out_word = {RX_WORD[15:8], read_reg(s_q, ra)};
            s_d.out_pend = 1'b1;
          end else begin
            if (s_q.clk_echo[`CE_ECHO]) begin
              s_d.out_word = RX_WORD;
              s_d.out_pend = 1'b1;
            end
            case (ra)
              `REG_MODE: begin
                if (val[`MODE_SW_RESET]) begin
                  s_d.mode = ST_SW_RESET;
                  s_d.rst_cnt = 3'h0;
                end else begin
                  s_d.mode_ctrl = val;
                  if (val[`MODE_DATA_SEL] && !val[`MODE_MIXED]) begin
                    s_d.mode = ST_DATA;
                  end
                end
              end
              `REG_CLK_ECHO: begin
                s_d.clk_echo = val;
                s_d.rate_fast = 1'b1;
              end
              `REG_POWER: begin
                s_d.power = val;
              end
              `REG_GAIN: begin
                s_d.gain = val;
              end
              `REG_DAC_TIMING: begin
                s_d.dac_timing = val;
              end
              default: begin
              end
            endcase
          end
        end
      end
      ST_DATA: begin
        if (INPUT_FRAME_SYNC) begin
          s_d.ifs_cnt = next_cnt[2:0];
          // A zero count stands for a lone codec
          if (next_cnt == {1'b0, (dc == 3'h0) ? 3'h1 : dc}) begin
            s_d.dac_data = RX_WORD;
            s_d.dac_load = 1'b1;
          end
        end
      end
      ST_SW_RESET: begin
        if (dm_tick) begin
          if (s_q.rst_cnt == `SWRESET_DMCLKS - 3'h1) begin
            s_d.mode = ST_PROGRAM;
          end else begin
            s_d.rst_cnt = s_q.rst_cnt + 3'h1;
          end
        end
      end
      default: begin
        s_d.mode = ST_PROGRAM;
      end
    endcase

    // registers read zero from the first busy cycle
    // Clearing on entry too, so no stale setting survives into the busy window
    if (s_d.mode == ST_SW_RESET) begin
      s_d.mode_ctrl = `REG_RESET_VAL;
      s_d.clk_echo = `REG_RESET_VAL;
      s_d.power = `REG_RESET_VAL;
      s_d.gain = `REG_RESET_VAL;
      s_d.dac_timing = `REG_RESET_VAL;
      s_d.rate_fast = 1'b0;
      s_d.out_pend = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // hardware reset clears everything at once
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
    end else if (CLK_EN) begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Link and converter outputs
  assign OUTPUT_FRAME_SYNC = s_q.ofs;
  assign TX_WORD = s_q.tx_word;
  assign SERIAL_CLOCK_TICK = s_tick;
  assign DIVIDED_MASTER_CLOCK_TICK = dm_tick;
  assign DAC_DATA = s_q.dac_data;
  assign DAC_LOAD = s_q.dac_load;
  assign DATA_MODE = (s_q.mode == ST_DATA);
  assign SOFT_RESET_BUSY = (s_q.mode == ST_SW_RESET);

  assign SERIAL_CLOCK_DIVIDER = s_q.clk_echo[`CE_SCD_HI:`CE_SCD_LO];
  assign MASTER_CLOCK_DIVIDER = s_q.clk_echo[`CE_MCD_HI:`CE_MCD_LO];
  assign CONTROL_ECHO_ENABLE = s_q.clk_echo[`CE_ECHO];

  assign ADC_POWER_ON = section_on(s_q.power, `PW_ADC);
  assign DAC_POWER_ON = section_on(s_q.power, `PW_DAC);
  assign REFERENCE_POWER_ON = section_on(s_q.power, `PW_REF);
  assign REFERENCE_OUTPUT_USE = s_q.power[`PW_REFOUT];
  assign HIGH_SUPPLY_MODE = s_q.power[`PW_HIGH_SUPPLY];

  assign INPUT_GAIN_SELECT = s_q.gain[`GN_IGS_HI:`GN_IGS_LO];
  assign OUTPUT_GAIN_SELECT = s_q.gain[`GN_OGS_HI:`GN_OGS_LO];
  assign MODULATOR_RESET = s_q.gain[`GN_MOD_RESET];
  assign OUTPUT_MUTE = s_q.gain[`GN_MUTE];

  assign DAC_ADVANCE = s_q.dac_timing[`DT_ADV_HI:`DT_ADV_LO];
  assign INTERPOLATOR_BYPASS = s_q.dac_timing[`DT_BYPASS];

endmodule

// ---- test/codec_frame_ctrl_properties.sv ----
`timescale 1ns/1ns
module codec_frame_checker (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // Frames and modes
  input wire logic INPUT_FRAME_SYNC,
  input wire logic [15:0] RX_WORD,
  input wire logic OUTPUT_FRAME_SYNC,
  input wire logic [15:0] DAC_DATA,
  input wire logic DAC_LOAD,
  input wire logic DATA_MODE,
  input wire logic SOFT_RESET_BUSY,
  // Settings
  input wire logic ADC_POWER_ON,
  input wire logic [2:0] INPUT_GAIN_SELECT,
  input wire logic [2:0] OUTPUT_GAIN_SELECT,
  input wire logic MODULATOR_RESET,
  input wire logic OUTPUT_MUTE,
  input wire logic [4:0] DAC_ADVANCE
);
  logic wr_ok;
  logic [15:0] rx_q;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);
  // A write the device must take as its own
  assign wr_ok = INPUT_FRAME_SYNC && CLK_EN && !DATA_MODE && !SOFT_RESET_BUSY
    && RX_WORD[15:11] == 5'h10;
  always_ff @(posedge REF_CLK) begin
    rx_q <= RX_WORD;
  end
  a_sync_gap: assert property (OUTPUT_FRAME_SYNC |=> !OUTPUT_FRAME_SYNC [*7])
    else $error("Output syncs too close");
  a_gain_write: assert property (wr_ok && RX_WORD[10:8] == 3'h3 |=>
    {OUTPUT_MUTE, OUTPUT_GAIN_SELECT, MODULATOR_RESET, INPUT_GAIN_SELECT} == rx_q[7:0])
    else $error("Gain write not applied");
  a_power_write: assert property (wr_ok && RX_WORD[10:8] == 3'h2 |=>
    ADC_POWER_ON == (rx_q[0] | rx_q[3]))
    else $error("Power write not applied");
  a_advance_write: assert property (wr_ok && RX_WORD[10:8] == 3'h4 |=>
    DAC_ADVANCE == rx_q[4:0])
    else $error("Advance write not applied");
  a_reserved_kept: assert property (wr_ok && RX_WORD[10:8] > 3'h4 |=>
    $stable(INPUT_GAIN_SELECT) && $stable(DAC_ADVANCE))
    else $error("Reserved write changed a setting");
  a_data_locked: assert property (DATA_MODE |=>
    DATA_MODE && $stable(OUTPUT_MUTE) && $stable(DAC_ADVANCE))
    else $error("Data mode left or settings changed");
  a_dac_load: assert property (DAC_LOAD |->
    $past(INPUT_FRAME_SYNC) && $past(DATA_MODE) && DAC_DATA == rx_q)
    else $error("DAC load without matching frame");
  a_load_pulse: assert property (DAC_LOAD |=> !DAC_LOAD)
    else $error("DAC load longer than a cycle");
  a_soft_clear: assert property (SOFT_RESET_BUSY |->
    INPUT_GAIN_SELECT == 3'h0 && DAC_ADVANCE == 5'h00 && !ADC_POWER_ON)
    else $error("Settings not cleared in soft reset");
  a_soft_len: assert property ($rose(SOFT_RESET_BUSY) |-> ##[1:40] !SOFT_RESET_BUSY)
    else $error("Soft reset too long");
  c_load: cover property (DAC_LOAD);
  c_soft: cover property ($rose(SOFT_RESET_BUSY));
  c_data: cover property ($rose(DATA_MODE));
endmodule

bind codec_frame_ctrl codec_frame_checker i_codec_frame_checker (
  .REF_CLK, .RESETN, .CLK_EN, .INPUT_FRAME_SYNC, .RX_WORD, .OUTPUT_FRAME_SYNC,
  .DAC_DATA, .DAC_LOAD, .DATA_MODE, .SOFT_RESET_BUSY, .ADC_POWER_ON,
  .INPUT_GAIN_SELECT, .OUTPUT_GAIN_SELECT, .MODULATOR_RESET, .OUTPUT_MUTE, .DAC_ADVANCE
);

// ---- test/host_link_model.sv ----
`timescale 1ns/1ns
module host_link_model (
  // Clock
  input wire logic clk,
  // From the device
  input wire logic out_sync,
  // To the device
  output logic in_sync,
  output logic [15:0] rx_word
);
  initial begin
    in_sync = 1'b0;
    rx_word = 16'h0000;
  end
  task automatic send(input logic [15:0] w0, input logic [15:0] w1, input int n);
    int t;
    t = 0;
    @(negedge clk);
    while (out_sync !== 1'b1 && t < 5000) begin
      @(negedge clk);
      t++;
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #2;
      in_sync = 1'b1;
      rx_word = (i == 0) ? w0 : w1;
    end
    @(posedge clk);
    #2;
    in_sync = 1'b0;
    // Released line shows the inverse, so a stale copy cannot pass
    rx_word = ~rx_word;
  endtask
endmodule

// ---- test/codec_frame_ctrl_tb_top.sv ----
`timescale 1ns/1ns
module codec_frame_ctrl_tb_top;
  logic ref_clk, resetn, se, fs, ofs, dload, dmode, busy, in_data, dtick, stick;
  logic [15:0] rx, tx, adc, ddata, w;
  logic [24:0] cfg;
  logic [7:0] ce, pw, gn, dt, d;
  int num_errors, samples_checked, cycles, seed, loads, nsync, dticks, sticks;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Short frame periods keep the run brief
  codec_frame_ctrl #(.FS_SLOW_PERIOD(12'h010), .FS_FAST_PERIOD(12'h008)) i_codec_frame_ctrl (
    .REF_CLK(ref_clk), .RESETN(resetn), .CLK_EN(1'b1), .SERIAL_ENABLE_PIN(se),
    .INPUT_FRAME_SYNC(fs), .RX_WORD(rx), .OUTPUT_FRAME_SYNC(ofs), .TX_WORD(tx),
    .SERIAL_CLOCK_TICK(stick), .DIVIDED_MASTER_CLOCK_TICK(dtick), .ADC_SAMPLE(adc),
    .DAC_DATA(ddata), .DAC_LOAD(dload), .DATA_MODE(dmode), .SOFT_RESET_BUSY(busy),
    .SERIAL_CLOCK_DIVIDER(cfg[24:23]), .MASTER_CLOCK_DIVIDER(cfg[22:20]),
    .CONTROL_ECHO_ENABLE(cfg[19]), .ADC_POWER_ON(cfg[18]), .DAC_POWER_ON(cfg[17]),
    .REFERENCE_POWER_ON(cfg[16]), .REFERENCE_OUTPUT_USE(cfg[15]), .HIGH_SUPPLY_MODE(cfg[14]),
    .INPUT_GAIN_SELECT(cfg[13:11]), .OUTPUT_GAIN_SELECT(cfg[10:8]), .MODULATOR_RESET(cfg[7]),
    .OUTPUT_MUTE(cfg[6]), .DAC_ADVANCE(cfg[5:1]), .INTERPOLATOR_BYPASS(cfg[0])
  );
  host_link_model i_host_link_model (.clk(ref_clk), .out_sync(ofs), .in_sync(fs), .rx_word(rx));
  ////////////////////////////////////////
  function automatic logic [24:0] exp_cfg();
    return {ce[3:2], ce[6:4], ce[7], pw[0] | pw[3], pw[0] | pw[4], pw[0] | pw[5], pw[6],
      pw[7], gn[2:0], gn[6:4], gn[3], gn[7], dt[4:0], dt[5]};
  endfunction
  task automatic check(input string name, input logic [24:0] seen, input logic [24:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_sync();
    int t;
    t = 0;
    do begin
      @(negedge ref_clk);
      t++;
    end while (ofs !== 1'b1 && t < 5000);
  endtask
  task automatic period(input int exp, input int dm, input int sc);
    int n;
    n = 0;
    dticks = 0;
    sticks = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (ofs !== 1'b1 && n < 5000);
    check("period", 25'(n), 25'(exp));
    check("dm ticks", 25'(dticks), 25'(dm));
    check("serial ticks", 25'(sticks), 25'(sc));
  endtask
  task automatic wr(input logic [2:0] r, input logic [7:0] v);
    i_host_link_model.send({5'h10, r, v}, 16'h0000, 1);
    @(negedge ref_clk);
    if (!in_data) begin
      if (r == 3'h1) ce = v;
      if (r == 3'h2) pw = v;
      if (r == 3'h3) gn = v;
      if (r == 3'h4) dt = v;
      if (r == 3'h0 && v[7]) {ce, pw, gn, dt} = 32'h0;
      if (r == 3'h0 && v[0] && !v[1] && !v[7]) in_data = 1'b1;
    end
    check("settings", cfg, exp_cfg());
  endtask
  task automatic rd(input logic [2:0] r, input logic [7:0] v);
    i_host_link_model.send({5'h18, r, 8'h5a}, 16'h0000, 1);
    wait_sync();
    check("readback", 25'(tx), 25'({5'h18, r, v}));
  endtask
  task automatic end_sim();
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    #2;
    adc = 16'($random(seed));
    cycles++;
    if (dtick === 1'b1) dticks++;
    if (stick === 1'b1) sticks++;
    if (dload === 1'b1) loads++;
    if (ofs === 1'b1) nsync++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    seed = 76;
    {resetn, se, in_data, adc} = '0;
    {ce, pw, gn, dt} = 32'h0;
    repeat (12) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    check("reset", cfg, 25'h0);
    repeat (40) @(posedge ref_clk);
    check("quiet", 25'(nsync), 25'h0);
    #2;
    se = 1'b1;
    wait_sync();
    period(16, 16, 2);
    for (int i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      w[15] = 1'b1;
      if (w[13:11] == 3'h0) w[11] = 1'b1;
      i_host_link_model.send(w, 16'h0000, 1);
      wait_sync();
      check("forward", 25'(tx), 25'({w[15:14], w[13:11] - 3'h1, w[10:0]}));
    end
    for (int i = 0; i < 9; i++) begin
      d = 8'($random(seed));
      if (i % 3 == 0) d[2:1] = 2'h0;
      if (i % 3 == 2) d[7:6] = 2'h0;
      wr(3'h2 + 3'(i % 3), d);
    end
    rd(3'h2, pw);
    rd(3'h3, gn);
    rd(3'h6, 8'h00);
    for (int i = 5; i < 8; i++) begin
      wr(3'(i), 8'($random(seed)));
      check("kept", cfg, exp_cfg());
    end
    i_host_link_model.send(16'h0377, 16'h0000, 1);
    @(negedge ref_clk);
    check("data word", cfg, exp_cfg());
    wait_sync();
    check("idle out", 25'(tx), 25'h0);
    // ones in low bits; echo applies from the next write
    wr(3'h1, 8'hab);
    wr(3'h1, 8'hab);
    wait_sync();
    check("echo", 25'(tx), 25'h081ab);
    period(24, 8, 4);
    wr(3'h0, 8'h80);
    check("busy", 25'(busy), 25'h1);
    wait_sync();
    period(16, 16, 2);
    wr(3'h0, 8'h21);
    check("data mode", 25'(dmode), 25'h1);
    loads = 0;
    w = 16'($random(seed));
    i_host_link_model.send(~w, w, 2);
    repeat (2) @(negedge ref_clk);
    check("loads", 25'(loads), 25'h1);
    check("dac", 25'(ddata), 25'(w));
    wr(3'h3, 8'hff);
    check("locked", cfg, exp_cfg());
    end_sim();
  end
endmodule
